// *** core/cs_pkg.sv ***
// shared constants, types and helpers for the compare-and-skip execution unit
// assumes a single 250 MHz core clock, with four clock edges per instruction cycle
// Functional notes
// - skip when file byte greater than working register
// - skip when file byte less than working register
// - compare alters no flag and no register
// - one cycle, two when skipping, three past two-word
// - bank bit 0 access bank, 1 uses bank select
// - extended set: bank bit 0, f<=95 is indexed
// - accept any 8-bit address and either bank bit
// - program counter ends past skipped instruction
package cs_pkg;

    // widths of the data path
    localparam int unsigned DATA_W     = 8;                // file register width
    localparam int unsigned ADDR_W     = 12;               // data memory address width
    localparam int unsigned BANK_W     = 4;                // bank select width
    localparam int unsigned INSTR_W    = 16;               // program word width
    localparam int unsigned PC_W       = 21;               // program counter width

    // opcode fields
    localparam int unsigned OP_HI      = 15;               // top bit of the opcode field
    localparam int unsigned OP_LO      = 9;                // low bit of the opcode field
    localparam int unsigned BANK_BIT   = 8;                // bank-access bit position
    localparam int unsigned F_HI       = 7;                // top bit of the file address

    // opcode patterns of the two compare instructions
    localparam logic [6:0]  OP_CMP_GT  = 7'h32;            // 0110 010
    localparam logic [6:0]  OP_CMP_LT  = 7'h30;            // 0110 000

    // addressing constants
    localparam logic [7:0]  INDEX_MAX  = 8'h5F;            // highest indexed literal offset
    localparam logic [7:0]  ACC_SPLIT  = 8'h80;            // access bank lower/upper split
    localparam logic [3:0]  ACC_LO_BNK = 4'h0;             // bank of the lower access half
    localparam logic [3:0]  ACC_HI_BNK = 4'hF;             // bank of the upper access half

    // program counter handling
    localparam logic [20:0] PC_RESET   = 21'h0_0000;       // counter after reset
    localparam logic [20:0] PC_STEP    = 21'h0_0002;       // bytes per program word
    localparam logic [15:0] NOP_WORD   = 16'h0000;         // no-operation encoding

    // two-word instruction patterns
    localparam logic [3:0]  TW_MOVE    = 4'hC;             // register-to-register move
    localparam logic [6:0]  TW_CALL    = 7'h76;            // call, 1110 110
    localparam logic [7:0]  TW_LOADFSR = 8'hEE;            // pointer load
    localparam logic [7:0]  TW_GOTO    = 8'hEF;            // long jump
    localparam logic [7:0]  TW_EXTMOV  = 8'hEB;            // extended-set indexed moves

    // phase within the instruction cycle, one-hot
    typedef enum logic [3:0] {
        PH_Q1 = 4'b0001,
        PH_Q2 = 4'b0010,
        PH_Q3 = 4'b0100,
        PH_Q4 = 4'b1000
    } cs_phase_t;

    // what the current instruction cycle does, one-hot
    typedef enum logic [2:0] {
        ST_EXEC  = 3'b001,  // normal execution
        ST_SKIP  = 3'b010,  // discarded first word
        ST_SKIP2 = 3'b100   // discarded second word
    } cs_state_t;

    // true when a program word opens a two-word instruction
    function automatic logic two_word(input logic [15:0] w);
        two_word = (w[15:12] == TW_MOVE) || (w[15:9] == TW_CALL)
                || (w[15:8] == TW_LOADFSR) || (w[15:8] == TW_GOTO)
                || (w[15:8] == TW_EXTMOV);
    endfunction

endpackage

// *** core/cs_file_mem.sv ***
// data memory of file registers with one write port and a registered read port
// assumes writes come from the rest of the core on the same clock
module cs_file_mem #(
    parameter int unsigned DW = 8,      // byte width
    parameter int unsigned AW = 12      // address width
) (
    input  wire logic          clk,
    input  wire logic          we,
    input  wire logic [AW-1:0] waddr,
    input  wire logic [DW-1:0] wdata,
    input  wire logic [AW-1:0] raddr,
    output logic      [DW-1:0] rdata
);

    // storage array
    logic [DW-1:0] mem [0:(1<<AW)-1];

    // write on edges with we set, registered read on every edge
    always_ff @(posedge clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
        rdata <= mem[raddr];
    end

endmodule

// *** core/cs_compare_skip.sv ***
// compare-and-skip execution unit with fetch counter and four-phase sequencer
// assumes instr_word is the program word at fetch_addr, valid in phase four
module cs_compare_skip #(
    parameter int unsigned AW = cs_pkg::ADDR_W   // data memory address width
) (
    input  wire logic                      clk,
    input  wire logic                      rst_b,
    input  wire logic [cs_pkg::INSTR_W-1:0] instr_word,
    input  wire logic [cs_pkg::DATA_W-1:0]  working_register,
    input  wire logic [cs_pkg::BANK_W-1:0]  bank_select_register,
    input  wire logic                      ext_set_en,
    input  wire logic [AW-1:0]             index_base,
    input  wire logic                      mem_we,
    input  wire logic [AW-1:0]             mem_waddr,
    input  wire logic [cs_pkg::DATA_W-1:0]  mem_wdata,
    output logic      [cs_pkg::PC_W-1:0]    fetch_addr,
    output logic      [3:0]                phase,
    output logic                           nop_cycle,
    output logic                           skip_taken
);

    // complete state of the unit
    typedef struct packed {
        cs_pkg::cs_phase_t          phase;  // phase within cycle
        cs_pkg::cs_state_t          st;     // cycle kind
        logic [cs_pkg::INSTR_W-1:0] ir;     // word being executed
        logic [cs_pkg::PC_W-1:0]    pc;     // next fetch address
        logic [AW-1:0]              addr;   // decoded file address
        logic                       hit;    // compare asks for a skip
        logic                       nop;    // current cycle is discarded
    } cs_regs_t;

    cs_regs_t                   s_q;        // registered state
    cs_regs_t                   s_d;        // next state
    logic [cs_pkg::DATA_W-1:0]  rd;         // file byte read in phase two
    logic [cs_pkg::DATA_W:0]    diff;       // f minus w with borrow
    logic                       is_gt;      // greater-than compare decoded
    logic                       is_lt;      // less-than compare decoded
    logic [7:0]                 f_lit;      // file address operand

    // file registers, read only from this unit
    cs_file_mem #(
        .DW (cs_pkg::DATA_W),
        .AW (AW)
    ) u_mem (
        .clk   (clk),
        .we    (mem_we),
        .waddr (mem_waddr),
        .wdata (mem_wdata),
        .raddr (s_q.addr),
        .rdata (rd)
    );

    // opcode decode of the word in the execute slot
    assign is_gt = (s_q.ir[cs_pkg::OP_HI:cs_pkg::OP_LO] == cs_pkg::OP_CMP_GT);
    assign is_lt = (s_q.ir[cs_pkg::OP_HI:cs_pkg::OP_LO] == cs_pkg::OP_CMP_LT);
    assign f_lit = s_q.ir[cs_pkg::F_HI:0];

    // unsigned subtraction; only its sign and zero test are used
    assign diff = {1'b0, rd} - {1'b0, working_register};

    // next-state logic
    always_comb begin
        s_d = s_q;
        case (s_q.phase)
            cs_pkg::PH_Q1: begin
                // decode and address only in an executing cycle
                s_d.phase = cs_pkg::PH_Q2;
                if (s_q.st == cs_pkg::ST_EXEC) begin
                    if (s_q.ir[cs_pkg::BANK_BIT]) begin
                        // banked: bank select supplies the upper bits
                        s_d.addr = AW'({bank_select_register, f_lit});
                    end else if (ext_set_en && (f_lit <= cs_pkg::INDEX_MAX)) begin
                        // indexed literal offset from the index base
                        s_d.addr = index_base + AW'(f_lit);
                    end else if (f_lit < cs_pkg::ACC_SPLIT) begin
                        // lower half of the access bank
                        s_d.addr = AW'({cs_pkg::ACC_LO_BNK, f_lit});
                    end else begin
                        // upper half of the access bank
                        s_d.addr = AW'({cs_pkg::ACC_HI_BNK, f_lit});
                    end
                end
            end
            cs_pkg::PH_Q2: begin
                // memory registers the byte at s_q.addr on this edge
                s_d.phase = cs_pkg::PH_Q3;
            end
            cs_pkg::PH_Q3: begin
                // compare; no flag or register is written
                s_d.phase = cs_pkg::PH_Q4;
                if (s_q.st != cs_pkg::ST_EXEC) begin
                    s_d.hit = 1'b0;
                end else if (is_gt) begin
                    s_d.hit = !diff[cs_pkg::DATA_W] && (diff != '0);
                end else if (is_lt) begin
                    s_d.hit = diff[cs_pkg::DATA_W];
                end else begin
                    s_d.hit = 1'b0;
                end
            end
            cs_pkg::PH_Q4: begin
                // fetch the next word and advance the counter each cycle
                s_d.phase = cs_pkg::PH_Q1;
                s_d.ir    = instr_word;
                s_d.pc    = s_q.pc + cs_pkg::PC_STEP;
                s_d.hit   = 1'b0;
                case (s_q.st)
                    cs_pkg::ST_EXEC: begin
                        // a hit discards the word fetched now
                        s_d.st = s_q.hit ? cs_pkg::ST_SKIP : cs_pkg::ST_EXEC;
                    end
                    cs_pkg::ST_SKIP: begin
                        // a two-word victim costs one more idle cycle
                        s_d.st = cs_cmp_two(s_q.ir) ? cs_pkg::ST_SKIP2
                                                    : cs_pkg::ST_EXEC;
                    end
                    cs_pkg::ST_SKIP2: begin
                        s_d.st = cs_pkg::ST_EXEC;
                    end
                    default: begin
                        s_d.st = cs_pkg::ST_EXEC;
                    end
                endcase
                // registered copy of the cycle kind keeps the output glitch free
                s_d.nop = (s_d.st != cs_pkg::ST_EXEC);
            end
            default: begin
                // recover from an illegal phase code
                s_d.phase = cs_pkg::PH_Q1;
            end
        endcase
    end

    // thin wrapper keeps the package helper call in one place
    function automatic logic cs_cmp_two(input logic [15:0] w);
        cs_cmp_two = cs_pkg::two_word(w);
    endfunction

    // state register with synchronous reset
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            s_q.phase <= cs_pkg::PH_Q1;
            s_q.st    <= cs_pkg::ST_EXEC;
            s_q.ir    <= cs_pkg::NOP_WORD;
            s_q.pc    <= cs_pkg::PC_RESET;
            s_q.addr  <= '0;
            s_q.hit   <= 1'b0;
            s_q.nop   <= 1'b0;
        end else begin
            s_q <= s_d;
        end
    end

    // outputs straight from the state register
    assign fetch_addr = s_q.pc;
    assign phase      = s_q.phase;
    assign nop_cycle  = s_q.nop;
    assign skip_taken = s_q.hit;

    // checks
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);

    greater_skip_a: assert property (
        (s_q.phase == cs_pkg::PH_Q3 && s_q.st == cs_pkg::ST_EXEC && is_gt)
        |=> (s_q.hit == ($past(rd) > $past(working_register))))
        else $error("greater compare gave the wrong skip decision");

    less_skip_a: assert property (
        (s_q.phase == cs_pkg::PH_Q3 && s_q.st == cs_pkg::ST_EXEC && is_lt)
        |=> (s_q.hit == ($past(rd) < $past(working_register))))
        else $error("less compare gave the wrong skip decision");

    no_side_hit_a: assert property (
        (s_q.phase == cs_pkg::PH_Q3 && !is_gt && !is_lt) |=> !s_q.hit)
        else $error("skip raised by a non-compare word");

    skip_enter_a: assert property (
        (s_q.phase == cs_pkg::PH_Q4 && s_q.st == cs_pkg::ST_EXEC && s_q.hit)
        |=> (s_q.st == cs_pkg::ST_SKIP) [*4] ##1 (s_q.st != cs_pkg::ST_SKIP))
        else $error("skipped cycle not exactly four edges long");

    skip_two_a: assert property (
        (s_q.phase == cs_pkg::PH_Q4 && s_q.st == cs_pkg::ST_SKIP)
        |=> (s_q.st == (cs_pkg::two_word($past(s_q.ir)) ? cs_pkg::ST_SKIP2
                                                        : cs_pkg::ST_EXEC)))
        else $error("second skipped cycle decision wrong");

    bank_addr_a: assert property (
        (s_q.phase == cs_pkg::PH_Q1 && s_q.st == cs_pkg::ST_EXEC
         && s_q.ir[cs_pkg::BANK_BIT])
        |=> (s_q.addr == AW'({$past(bank_select_register), $past(f_lit)})))
        else $error("banked address not built from bank select");

    index_addr_a: assert property (
        (s_q.phase == cs_pkg::PH_Q1 && s_q.st == cs_pkg::ST_EXEC
         && !s_q.ir[cs_pkg::BANK_BIT] && ext_set_en && f_lit <= cs_pkg::INDEX_MAX)
        |=> (s_q.addr == $past(index_base) + AW'($past(f_lit))))
        else $error("indexed literal offset address wrong");

    pc_step_a: assert property (
        (s_q.phase == cs_pkg::PH_Q4) |=> (s_q.pc == $past(s_q.pc) + cs_pkg::PC_STEP))
        else $error("counter did not advance by one word");

    phase_walk_a: assert property (
        (s_q.phase == cs_pkg::PH_Q1) |=> (s_q.phase == cs_pkg::PH_Q2)
        ##1 (s_q.phase == cs_pkg::PH_Q3) ##1 (s_q.phase == cs_pkg::PH_Q4)
        ##1 (s_q.phase == cs_pkg::PH_Q1))
        else $error("phase sequence broken");

    skip_idle_a: assert property (
        (s_q.st != cs_pkg::ST_EXEC) |=> (s_q.addr == $past(s_q.addr)))
        else $error("discarded cycle moved the file address");

endmodule

// *** bench/cs_compare_skip_tb.sv ***
// self-checking bench for the compare-and-skip execution unit
// assumes core/cs_pkg.sv and core/cs_compare_skip.sv are compiled first, 4 ns clock
module cs_compare_skip_tb;
    timeunit 1ns;
    timeprecision 100ps;

    logic                         clk;                  // core clock
    logic                         rst_b;                // synchronous reset, active low
    logic [cs_pkg::INSTR_W-1:0]   instr_word;           // program word fed in phase four
    logic [cs_pkg::DATA_W-1:0]    working_register;     // value compared against
    logic [cs_pkg::BANK_W-1:0]    bank_select_register; // upper address bits when a=1
    logic                         ext_set_en;           // extended set enable
    logic [11:0]                  index_base;           // base of indexed offsets
    logic                         mem_we;               // file memory write strobe
    logic [11:0]                  mem_waddr;            // file memory write address
    logic [cs_pkg::DATA_W-1:0]    mem_wdata;            // file memory write data
    logic [cs_pkg::PC_W-1:0]      fetch_addr;           // program counter seen
    logic [3:0]                   phase;                // one-hot phase seen
    logic                         nop_cycle;            // discarded cycle flag
    logic                         skip_taken;           // skip decision flag
    int                           n_errors;             // mismatches counted
    int                           n_tests;              // comparisons made
    int                           n_fetch;              // words fetched so far

    cs_compare_skip #(.AW(12)) dut (
        .clk(clk), .rst_b(rst_b), .instr_word(instr_word),
        .working_register(working_register), .bank_select_register(bank_select_register),
        .ext_set_en(ext_set_en), .index_base(index_base), .mem_we(mem_we),
        .mem_waddr(mem_waddr), .mem_wdata(mem_wdata), .fetch_addr(fetch_addr),
        .phase(phase), .nop_cycle(nop_cycle), .skip_taken(skip_taken)
    );

    // free-running clock
    always #2 clk = ~clk;

    // every phase-four edge fetches one word, two bytes apart
    always @(posedge clk) begin
        if (rst_b !== 1'b1) begin
            n_fetch <= 0;
        end else if (phase === 4'b1000) begin
            n_fetch <= n_fetch + 1;
        end
    end

    // compare one value, counting every call
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    // one clock, inputs move just after the edge
    task automatic tick();
        @(posedge clk);
        #1;
    endtask

    // compare opcode: 0110 0g0a ffff ffff, g set for greater
    function automatic logic [15:0] cmp_op(input logic gt, input logic a, input logic [7:0] f);
        cmp_op = {4'b0110, 1'b0, gt, 1'b0, a, f};
    endfunction

    // feed a word in phase four and judge the cycle that follows
    task automatic exec(input logic [15:0] w, input logic [7:0] wr,
                        input logic e_nop, input logic e_skip);
        instr_word = w;
        working_register = wr;
        tick();
        chk("nop_cycle_q1", {31'h0, e_nop}, {31'h0, nop_cycle});
        chk("fetch_addr", 2 * n_fetch, {11'h0, fetch_addr});
        repeat (3) tick();
        chk("phase_q4", 32'h0000_0008, {28'h0, phase});
        chk("nop_cycle_q4", {31'h0, e_nop}, {31'h0, nop_cycle});
        chk("skip_taken", {31'h0, e_skip}, {31'h0, skip_taken});
    endtask

    // greater: strictly above skips, equal and below do not
    task automatic t_greater();
        exec(cmp_op(1'b1, 1'b0, 8'h10), 8'h7F, 1'b0, 1'b1);
        exec(16'h1234, 8'h00, 1'b1, 1'b0);
        exec(cmp_op(1'b1, 1'b0, 8'h10), 8'h80, 1'b0, 1'b0);
        exec(cmp_op(1'b1, 1'b0, 8'h10), 8'h81, 1'b0, 1'b0);
    endtask

    // less: upper access half maps high, equal and above do not skip
    task automatic t_less();
        exec(cmp_op(1'b0, 1'b0, 8'h90), 8'h02, 1'b0, 1'b1);
        exec(16'h1234, 8'h00, 1'b1, 1'b0);
        exec(cmp_op(1'b0, 1'b0, 8'h90), 8'h01, 1'b0, 1'b0);
        exec(cmp_op(1'b0, 1'b0, 8'h90), 8'h00, 1'b0, 1'b0);
    endtask

    // bank bit set takes the bank select, clear takes the access bank
    task automatic t_bank();
        bank_select_register = 4'h3;
        exec(cmp_op(1'b1, 1'b1, 8'hFF), 8'h0F, 1'b0, 1'b1);
        exec(16'h1234, 8'h00, 1'b1, 1'b0);
        exec(cmp_op(1'b1, 1'b0, 8'hFF), 8'h0F, 1'b0, 1'b0);
    endtask

    // extended set: offsets up to 5f are indexed, 60 and a=1 are not
    task automatic t_index();
        ext_set_en = 1'b1;
        index_base = 12'h200;
        exec(cmp_op(1'b1, 1'b0, 8'h5F), 8'h20, 1'b0, 1'b1);
        exec(16'h1234, 8'h00, 1'b1, 1'b0);
        exec(cmp_op(1'b1, 1'b0, 8'h60), 8'h20, 1'b0, 1'b0);
        exec(cmp_op(1'b1, 1'b1, 8'hFF), 8'h0F, 1'b0, 1'b1);
        exec(16'h1234, 8'h00, 1'b1, 1'b0);
        ext_set_en = 1'b0;
        exec(cmp_op(1'b1, 1'b0, 8'h5F), 8'h20, 1'b0, 1'b0);
    endtask

    // skip over every two-word opener costs two discarded cycles
    task automatic t_two_word();
        logic [15:0] opener [5];
        opener = '{16'hC123, 16'hEC45, 16'hEE10, 16'hEF20, 16'hEB30};
        foreach (opener[i]) begin
            exec(cmp_op(1'b0, 1'b0, 8'h90), 8'h02, 1'b0, 1'b1);
            exec(opener[i], 8'h00, 1'b1, 1'b0);
            exec(16'h5A5A, 8'h00, 1'b1, 1'b0);
            exec(16'h0000, 8'h00, 1'b0, 1'b0);
        end
    endtask

    // reset in mid-run, straight after a hit, drops the pending skip
    task automatic t_reset();
        exec(cmp_op(1'b1, 1'b0, 8'h10), 8'h7F, 1'b0, 1'b1);
        rst_b = 1'b0;
        tick();
        chk("phase_rst", 32'h0000_0001, {28'h0, phase});
        chk("fetch_addr_rst", 32'h0000_0000, {11'h0, fetch_addr});
        chk("nop_cycle_rst", 32'h0000_0000, {31'h0, nop_cycle});
        chk("skip_taken_rst", 32'h0000_0000, {31'h0, skip_taken});
        tick();
        rst_b = 1'b1;
        repeat (3) tick();
        exec(16'h1234, 8'h00, 1'b0, 1'b0);
    endtask

    // print counts and the verdict, then stop
    task report_and_stop();
        $display("errors %0d comparisons %0d", n_errors, n_tests);
        if (n_errors == 0 && n_tests > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // main sequence: reset, load memory, align to phase four, run scenarios
    initial begin
        logic [11:0] wa [9];
        logic [7:0]  wd [9];
        wa = '{12'h010, 12'hF90, 12'h090, 12'h3FF, 12'hFFF, 12'h25F, 12'h05F, 12'h060, 12'h260};
        wd = '{8'h80, 8'h01, 8'hFF, 8'h10, 8'h00, 8'h40, 8'h00, 8'h00, 8'h40};
        clk = 1'b0;
        rst_b = 1'b0;
        instr_word = 16'h0000;
        working_register = 8'h00;
        bank_select_register = 4'h0;
        ext_set_en = 1'b0;
        index_base = 12'h000;
        mem_we = 1'b0;
        mem_waddr = 12'h000;
        mem_wdata = 8'h00;
        n_errors = 0;
        n_tests = 0;
        n_fetch = 0;
        repeat (2) @(posedge clk);
        #1;
        rst_b = 1'b1;
        // one byte per edge into the file memory
        foreach (wa[i]) begin
            mem_we = 1'b1;
            mem_waddr = wa[i];
            mem_wdata = wd[i];
            tick();
        end
        mem_we = 1'b0;
        // bounded wait for phase four
        for (int k = 0; k < 8 && phase !== 4'b1000; k++) begin
            tick();
        end
        t_greater();
        t_less();
        t_bank();
        t_index();
        t_two_word();
        t_reset();
        report_and_stop();
    end

    // watchdog, far beyond the fewer than two hundred clock cycles the scenarios need
    initial begin
        #20000;
        n_errors++;
        report_and_stop();
    end
endmodule
